// File: hdl/der_defines.vh
`ifndef DER_DEFINES_VH
`define DER_DEFINES_VH
// ---------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define DER_IDX_ERR_CLASS   14'h1001
`define DER_IDX_EMCY_MASK   14'h1010
`define DER_IDX_FAULT_MASK  14'h1011
`define DER_IDX_FACT_MASK   14'h1012
`define DER_IDX_OFF_MASK    14'h1013
`define DER_IDX_QSTOP_MASK  14'h1014
`define DER_IDX_PIN_MASK    14'h1015
`define DER_IDX_PIN_SEL     14'h1016
`define DER_IDX_ROUTING     14'h1017
`define DER_IDX_CTRL        14'h1018
`define DER_IDX_TOL_US      14'h1019
`define DER_IDX_SUPPLY_MAX  14'h101A
`define DER_IDX_STATUS      14'h101B
`define DER_IDX_LOG_COUNT   14'h1020
`define DER_IDX_LOG_BASE    14'h1021
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DER_RST_FACT_MASK   16'h4024
`define DER_RST_OFF_MASK    16'h0000
`define DER_RST_QSTOP_MASK  16'h0000
`define DER_RST_FAULT_MASK  16'h0000
`define DER_RST_EMCY_MASK   16'hFFFF
`define DER_RST_PIN_MASK    16'h0000
`define DER_RST_PIN_SEL     8'h00
`define DER_RST_ROUTING     32'h0003_0302
`define DER_RST_TOL_US      16'h0064
`define DER_RST_SUPPLY_MAX  16'hFFFF
// ---------------------------------------------------------------
// routing word bit positions
// ---------------------------------------------------------------
`define DER_RT_NMT_REQ      0
`define DER_RT_CAN_MSG      1
`define DER_RT_USB_EMCY     8
`define DER_RT_USB_ASYNC    9
`define DER_RT_USB_NOBOOT   15
`define DER_RT_SER_EMCY     16
`define DER_RT_SER_ASYNC    17
`define DER_RT_NO_CRC       23
// ---------------------------------------------------------------
// limits and timing
// ---------------------------------------------------------------
`define DER_OVR_NUM         20'h0_000D
`define DER_OVR_DEN         20'h0_000A
`define DER_CLK_NS          4
`define DER_TICK_NS         1000
`define DER_TICK_CYC        (`DER_TICK_NS / `DER_CLK_NS)
`define DER_LED_HALF_US     250000
`define DER_LOG_DEPTH       8
`endif

// File: hdl/der_dispatch.v
`timescale 1ns/1ps
`include "der_defines.vh"

module der_dispatch #(
  parameter N_DOUT      = 8,
  parameter LED_HALF_US = `DER_LED_HALF_US
) (
  input  wire              I_SYS_CLK,
  input  wire              I_RST_B,
  // wishbone slave
  input  wire              I_WB_CYC,
  input  wire              I_WB_STB,
  input  wire              I_WB_WE,
  input  wire [15:0]       I_WB_ADR,
  input  wire [3:0]        I_WB_SEL,
  input  wire [31:0]       I_WB_DAT,
  output wire [31:0]       O_WB_DAT,
  output wire              O_WB_ACK,
  // error sources
  input  wire [15:0]       I_ERR_WORD,
  input  wire              I_ERR_EVENT,
  input  wire [15:0]       I_ERR_CODE,
  input  wire              I_SUPPLY_ABOVE,
  input  wire              I_ELEC_BELOW,
  input  wire [15:0]       I_SUPPLY_LEVEL,
  input  wire              I_TEMP_OVER,
  input  wire              I_SAFE_TORQUE_OFF,
  // drive state machine side
  input  wire              I_ENABLE_REQ,
  input  wire              I_NMT_OPER,
  input  wire              I_STATE_CHG,
  input  wire              I_OP_ENABLED,
  input  wire              I_FAULT_ACTIVE,
  input  wire              I_BOOT_FAIL,
  input  wire              I_BOOTLOADER,
  input  wire              I_NET_MODE,
  output wire              O_DRIVE_OFF,
  output wire              O_BRAKE,
  output wire              O_QUICK_STOP,
  output wire              O_FAULT_REQ,
  output wire              O_ENABLE_OK,
  output wire [N_DOUT-1:0] O_FAULT_DOUT,
  // message side
  output wire [63:0]       O_EMCY_DATA,
  output wire              O_EMCY_CAN,
  output wire              O_EMCY_USB,
  output wire              O_EMCY_SER,
  output wire              O_ASYNC_CAN,
  output wire              O_ASYNC_USB,
  output wire              O_ASYNC_SER,
  output wire              O_USB_BOOT_EN,
  output wire              O_IGNORE_CRC,
  output wire              O_LED_GREEN,
  output wire              O_LED_RED
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) merge[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
  endfunction

  // error word to error class bits, bit0 from any error
  function [7:0] err_class;
    input [15:0] w;
    begin
      err_class    = 8'h00;
      err_class[0] = |w;
      err_class[1] = w[4];
      err_class[2] = w[2] | w[3];
      err_class[3] = w[5];
      err_class[4] = w[11];
      err_class[5] = w[0] | w[1];
      err_class[7] = |w[9:6] | w[12] | w[13];
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [15:0] emcy_mask_q;
  reg  [15:0] fault_mask_q;
  reg  [15:0] off_mask_q;
  reg  [15:0] qstop_mask_q;
  reg  [15:0] pin_mask_q;
  reg  [7:0]  pin_sel_q;
  reg  [31:0] routing_q;
  reg         brake_cfg_q;
  reg  [15:0] tol_us_q;
  reg  [15:0] supply_max_q;
  reg  [7:0]  err_class_q;
  reg  [63:0] log_q [0:`DER_LOG_DEPTH-1];
  reg  [3:0]  log_cnt_q;
  reg         ack_q;
  reg  [31:0] rdat_q;
  reg  [31:0] rdat_d;
  wire [13:0] idx  = I_WB_ADR[15:2];
  wire        req  = I_WB_CYC & I_WB_STB;
  wire        wr   = req & I_WB_WE & ack_q;
  wire [31:0] wr_mrg = merge(rdat_d, I_WB_DAT, I_WB_SEL);       // current value with written lanes
  wire [15:0] fact_mask = `DER_RST_FACT_MASK;
  wire [13:0] log_off = idx - `DER_IDX_LOG_BASE;
  wire        log_hit = (idx >= `DER_IDX_LOG_BASE) &&
                        (idx < `DER_IDX_LOG_BASE + 2 * `DER_LOG_DEPTH);
  integer     i;

  // ---------------------------------------------------------------
  // response dispatch
  // ---------------------------------------------------------------
  wire        m_fact  = |(I_ERR_WORD & fact_mask);
  wire        m_off   = |(I_ERR_WORD & off_mask_q);
  wire        m_qstop = |(I_ERR_WORD & qstop_mask_q);
  wire        m_fault = |(I_ERR_WORD & fault_mask_q);
  reg  [15:0] ov_cnt_q;
  reg  [15:0] uv_cnt_q;
  reg  [7:0]  tick_cnt_q;
  reg         tick_q;
  wire        ov_trip = I_SUPPLY_ABOVE && (ov_cnt_q > tol_us_q);
  wire        uv_trip = I_ELEC_BELOW && (uv_cnt_q > tol_us_q);
  wire [19:0] lvl_x = {4'h0, I_SUPPLY_LEVEL} * `DER_OVR_DEN;
  wire [19:0] max_x = {4'h0, supply_max_q} * `DER_OVR_NUM;
  wire        over_max = lvl_x > max_x;
  wire        hw_off = ov_trip | uv_trip | over_max |
                       I_TEMP_OVER | I_SAFE_TORQUE_OFF;
  wire        off_d   = hw_off | m_fact | m_off;
  wire        qstop_d = ~off_d & m_qstop;
  wire        fault_d = ~off_d & ~m_qstop & m_fault & ~m_fact;
  reg         off_q;
  reg         qstop_q;
  reg         fault_q;
  reg         enable_q;
  reg         pin_q;
  wire        nmt_ok = ~routing_q[`DER_RT_NMT_REQ] | I_NMT_OPER;

  // microsecond tick divider
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == `DER_TICK_CYC - 1) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
      tick_q     <= 1'b0;
    end
  end

  // supply tolerance timers, saturating
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      ov_cnt_q <= 16'h0000;
      uv_cnt_q <= 16'h0000;
    end else begin
      if (!I_SUPPLY_ABOVE) ov_cnt_q <= 16'h0000;
      else if (tick_q && ov_cnt_q != 16'hFFFF) ov_cnt_q <= ov_cnt_q + 16'h0001;
      if (!I_ELEC_BELOW) uv_cnt_q <= 16'h0000;
      else if (tick_q && uv_cnt_q != 16'hFFFF) uv_cnt_q <= uv_cnt_q + 16'h0001;
    end
  end

  // registered responses, fault pin and enable gate
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      off_q    <= 1'b0;
      qstop_q  <= 1'b0;
      fault_q  <= 1'b0;
      enable_q <= 1'b0;
      pin_q    <= 1'b0;
    end else begin
      off_q    <= off_d;
      qstop_q  <= qstop_d;
      fault_q  <= fault_d;
      enable_q <= I_ENABLE_REQ & ~off_d & nmt_ok;
      pin_q    <= |(I_ERR_WORD & pin_mask_q);
    end
  end

  assign O_DRIVE_OFF  = off_q;
  assign O_BRAKE      = off_q & brake_cfg_q;
  assign O_QUICK_STOP = qstop_q;
  assign O_FAULT_REQ  = fault_q;
  assign O_ENABLE_OK  = enable_q;

  // fault pin routing, 0 selects no output
  genvar g;
  generate
    for (g = 0; g < N_DOUT; g = g + 1) begin : g_dout
      assign O_FAULT_DOUT[g] = pin_q && (pin_sel_q == g + 1);
    end
  endgenerate

  // ---------------------------------------------------------------
  // emergency messages and log
  // ---------------------------------------------------------------
  wire [7:0]  class_d  = err_class(I_ERR_WORD);
  wire        emcy_hit = I_ERR_EVENT & |(I_ERR_WORD & emcy_mask_q);
  wire [63:0] msg_d = {24'h00_0000, I_ERR_WORD[15:8], I_ERR_WORD[7:0],
                       class_d, I_ERR_CODE[15:8], I_ERR_CODE[7:0]};
  reg  [63:0] emcy_data_q;
  reg         emcy_can_q;
  reg         emcy_usb_q;
  reg         emcy_ser_q;
  reg         async_can_q;
  reg         async_usb_q;
  reg         async_ser_q;

  // message build and per-interface gating
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      emcy_data_q <= 64'h0000_0000_0000_0000;
      emcy_can_q  <= 1'b0;
      emcy_usb_q  <= 1'b0;
      emcy_ser_q  <= 1'b0;
      async_can_q <= 1'b0;
      async_usb_q <= 1'b0;
      async_ser_q <= 1'b0;
    end else begin
      if (emcy_hit) emcy_data_q <= msg_d;
      emcy_can_q  <= emcy_hit & routing_q[`DER_RT_CAN_MSG];
      emcy_usb_q  <= emcy_hit & routing_q[`DER_RT_USB_EMCY];
      emcy_ser_q  <= emcy_hit & routing_q[`DER_RT_SER_EMCY] & ~I_NET_MODE;
      async_can_q <= I_STATE_CHG & routing_q[`DER_RT_CAN_MSG];
      async_usb_q <= I_STATE_CHG & routing_q[`DER_RT_USB_ASYNC];
      async_ser_q <= I_STATE_CHG & routing_q[`DER_RT_SER_ASYNC] & ~I_NET_MODE;
    end
  end

  assign O_EMCY_DATA   = emcy_data_q;
  assign O_EMCY_CAN    = emcy_can_q;
  assign O_EMCY_USB    = emcy_usb_q;
  assign O_EMCY_SER    = emcy_ser_q;
  assign O_ASYNC_CAN   = async_can_q;
  assign O_ASYNC_USB   = async_usb_q;
  assign O_ASYNC_SER   = async_ser_q;
  assign O_USB_BOOT_EN = ~routing_q[`DER_RT_USB_NOBOOT];
  assign O_IGNORE_CRC  = routing_q[`DER_RT_NO_CRC];

  // error class register and log, newest entry at slot 0
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      err_class_q <= 8'h00;
      log_cnt_q   <= 4'h0;
      for (i = 0; i < `DER_LOG_DEPTH; i = i + 1) log_q[i] <= 64'h0000_0000_0000_0000;
    end else begin
      if (I_ERR_EVENT) err_class_q <= class_d;
      if (emcy_hit) begin
        for (i = `DER_LOG_DEPTH - 1; i > 0; i = i - 1) log_q[i] <= log_q[i-1];
        log_q[0] <= msg_d;
        if (log_cnt_q != `DER_LOG_DEPTH) log_cnt_q <= log_cnt_q + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // status LED
  // ---------------------------------------------------------------
  reg  [17:0] led_cnt_q;
  reg  [2:0]  led_ph_q;
  reg         green_q;
  reg         red_q;

  // half-period phase counter for flashing
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      led_cnt_q <= 18'h0_0000;
      led_ph_q  <= 3'h0;
    end else if (tick_q) begin
      if (led_cnt_q == LED_HALF_US - 1) begin
        led_cnt_q <= 18'h0_0000;
        led_ph_q  <= led_ph_q + 3'h1;
      end else begin
        led_cnt_q <= led_cnt_q + 18'h0_0001;
      end
    end
  end

  // pattern select, boot states take precedence
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      green_q <= 1'b0;
      red_q   <= 1'b0;
    end else begin
      green_q <= 1'b0;
      red_q   <= 1'b0;
      if (I_BOOTLOADER) red_q <= 1'b1;
      else if (I_BOOT_FAIL) red_q <= ~led_ph_q[0] & ~led_ph_q[2];
      else if (I_FAULT_ACTIVE) red_q <= led_ph_q[0];
      else if (I_OP_ENABLED) green_q <= 1'b1;
      else green_q <= led_ph_q[0];
    end
  end

  assign O_LED_GREEN = green_q;
  assign O_LED_RED   = red_q;

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  // read mux, unmapped reads as zero
  always @* begin
    rdat_d = 32'h0000_0000;
    if (log_hit) begin
      rdat_d = log_off[0] ? log_q[log_off[3:1]][63:32] : log_q[log_off[3:1]][31:0];
    end else begin
      case (idx)
        `DER_IDX_ERR_CLASS:  rdat_d = {24'h00_0000, err_class_q};
        `DER_IDX_EMCY_MASK:  rdat_d = {16'h0000, emcy_mask_q};
        `DER_IDX_FAULT_MASK: rdat_d = {16'h0000, fault_mask_q};
        `DER_IDX_FACT_MASK:  rdat_d = {16'h0000, fact_mask};
        `DER_IDX_OFF_MASK:   rdat_d = {16'h0000, off_mask_q};
        `DER_IDX_QSTOP_MASK: rdat_d = {16'h0000, qstop_mask_q};
        `DER_IDX_PIN_MASK:   rdat_d = {16'h0000, pin_mask_q};
        `DER_IDX_PIN_SEL:    rdat_d = {24'h00_0000, pin_sel_q};
        `DER_IDX_ROUTING:    rdat_d = {8'h00, routing_q[23:0]};
        `DER_IDX_CTRL:       rdat_d = {31'h0000_0000, brake_cfg_q};
        `DER_IDX_TOL_US:     rdat_d = {16'h0000, tol_us_q};
        `DER_IDX_SUPPLY_MAX: rdat_d = {16'h0000, supply_max_q};
        `DER_IDX_STATUS:     rdat_d = {26'h000_0000, enable_q, pin_q, fault_q,
                                       qstop_q, off_q, hw_off};
        `DER_IDX_LOG_COUNT:  rdat_d = {28'h000_0000, log_cnt_q};
        default:             rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // ack one cycle after request, write at the acked edge
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      ack_q        <= 1'b0;
      rdat_q       <= 32'h0000_0000;
      emcy_mask_q  <= `DER_RST_EMCY_MASK;
      fault_mask_q <= `DER_RST_FAULT_MASK;
      off_mask_q   <= `DER_RST_OFF_MASK;
      qstop_mask_q <= `DER_RST_QSTOP_MASK;
      pin_mask_q   <= `DER_RST_PIN_MASK;
      pin_sel_q    <= `DER_RST_PIN_SEL;
      routing_q    <= `DER_RST_ROUTING;
      brake_cfg_q  <= 1'b0;
      tol_us_q     <= `DER_RST_TOL_US;
      supply_max_q <= `DER_RST_SUPPLY_MAX;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) rdat_q <= rdat_d;
      if (wr) begin
        case (idx)
          `DER_IDX_EMCY_MASK:  emcy_mask_q  <= wr_mrg[15:0];
          `DER_IDX_FAULT_MASK: fault_mask_q <= wr_mrg[15:0];
          `DER_IDX_OFF_MASK:   off_mask_q   <= wr_mrg[15:0];
          `DER_IDX_QSTOP_MASK: qstop_mask_q <= wr_mrg[15:0];
          `DER_IDX_PIN_MASK:   pin_mask_q   <= wr_mrg[15:0];
          `DER_IDX_PIN_SEL:    pin_sel_q    <= wr_mrg[7:0];
          `DER_IDX_ROUTING:    routing_q    <= wr_mrg & 32'h00FF_FFFF;
          `DER_IDX_CTRL:       brake_cfg_q  <= wr_mrg[0];
          `DER_IDX_TOL_US:     tol_us_q     <= wr_mrg[15:0];
          `DER_IDX_SUPPLY_MAX: supply_max_q <= wr_mrg[15:0];
          default:             ;                                 // read-only or unmapped, dropped
        endcase
      end
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

endmodule

// File: test/der_dispatch_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the error dispatcher
// ----------------------------------------
module der_dispatch_monitor (
  input logic        I_SYS_CLK,
  input logic        I_RST_B,
  input logic [15:0] I_ERR_WORD,
  input logic        I_ERR_EVENT,
  input logic        I_TEMP_OVER,
  input logic        I_SAFE_TORQUE_OFF,
  input logic        I_NET_MODE,
  input logic        O_DRIVE_OFF,
  input logic        O_BRAKE,
  input logic        O_QUICK_STOP,
  input logic        O_FAULT_REQ,
  input logic        O_ENABLE_OK,
  input logic [63:0] O_EMCY_DATA,
  input logic        O_EMCY_CAN,
  input logic        O_EMCY_SER
);
  // one clock domain, reset low disables all
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);
  a_fact_mask_off: assert property ((I_ERR_WORD & 16'h4024) != 16'h0000 |=> O_DRIVE_OFF)
    else $error("factory mask match left drive on");
  a_fact_no_fault: assert property ((I_ERR_WORD & 16'h4024) != 16'h0000 |=> !O_FAULT_REQ && !O_QUICK_STOP)
    else $error("lower response applied on factory match");
  a_temp_trip_off: assert property (I_TEMP_OVER |=> O_DRIVE_OFF)
    else $error("over temperature left drive on");
  a_sto_trip_off: assert property (I_SAFE_TORQUE_OFF |=> O_DRIVE_OFF)
    else $error("torque off left drive on");
  a_enable_refused: assert property (O_DRIVE_OFF |-> !O_ENABLE_OK)
    else $error("enable granted while switched off");
  a_one_response: assert property (O_DRIVE_OFF |-> !O_QUICK_STOP && !O_FAULT_REQ)
    else $error("lower response applied with switch off");
  a_brake_needs_off: assert property (O_BRAKE |-> O_DRIVE_OFF)
    else $error("brake without switch off");
  a_emcy_pad_zero: assert property (O_EMCY_DATA[63:40] == 24'h00_0000)
    else $error("message pad bytes not zero");
  a_emcy_has_cause: assert property (O_EMCY_CAN |-> $past(I_ERR_EVENT))
    else $error("message without error event");
  a_ser_net_quiet: assert property (O_EMCY_SER |-> !$past(I_NET_MODE))
    else $error("serial message in net mode");
endmodule

// File: test/der_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// higher-level controller, message sink
// ----------------------------------------
module der_host_model (
  input  logic        i_clk,
  input  logic        i_rst_b,
  input  logic        i_emcy_can,
  input  logic [63:0] i_emcy_data,
  output logic [7:0]  o_count,
  output logic [63:0] o_last
);
  // takes each 8-byte frame whole on its pulse
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_count <= 8'h00;
      o_last  <= 64'h0000_0000_0000_0000;
    end else if (i_emcy_can === 1'b1) begin
      o_count <= o_count + 8'h01;
      o_last  <= i_emcy_data;
    end
  end
endmodule

// File: test/tb_der_dispatch.sv
`timescale 1ns/1ps
`include "der_defines.vh"
module tb_der_dispatch;
  logic clk = 0, rst_b = 0, cyc = 0, we = 0, ev = 0, sa = 0, tmp = 0, safe_torque_off = 0, en = 0, nmt = 0, net = 0;
  logic eb = 0, stc = 0;
  logic [15:0] adr = 0, word = 0, code = 0, lvl = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [3:0]  led = 0;
  logic        ack, off, brk, qs, fr, eok, ecan, eusb, eser, boot, icrc, grn, red;
  logic        acan, ausb, aser;
  logic [7:0]  dout, hcnt;
  logic [63:0] edat, hlast;
  int          bad_count = 0, checked = 0;
  always #2 clk = ~clk;
  der_dispatch #(.LED_HALF_US(4)) DUT (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(cyc),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_ERR_WORD(word), .I_ERR_EVENT(ev), .I_ERR_CODE(code), .I_SUPPLY_ABOVE(sa), .I_ELEC_BELOW(eb),
    .I_SUPPLY_LEVEL(lvl), .I_TEMP_OVER(tmp), .I_SAFE_TORQUE_OFF(safe_torque_off), .I_ENABLE_REQ(en), .I_NMT_OPER(nmt),
    .I_STATE_CHG(stc), .I_OP_ENABLED(led[3]), .I_FAULT_ACTIVE(led[2]), .I_BOOT_FAIL(led[1]),
    .I_BOOTLOADER(led[0]), .I_NET_MODE(net), .O_DRIVE_OFF(off), .O_BRAKE(brk), .O_QUICK_STOP(qs),
    .O_FAULT_REQ(fr), .O_ENABLE_OK(eok), .O_FAULT_DOUT(dout), .O_EMCY_DATA(edat), .O_EMCY_CAN(ecan),
    .O_EMCY_USB(eusb), .O_EMCY_SER(eser), .O_ASYNC_CAN(acan), .O_ASYNC_USB(ausb), .O_ASYNC_SER(aser),
    .O_USB_BOOT_EN(boot), .O_IGNORE_CRC(icrc), .O_LED_GREEN(grn), .O_LED_RED(red));
  der_host_model u_host (.i_clk(clk), .i_rst_b(rst_b), .i_emcy_can(ecan), .i_emcy_data(edat),
    .o_count(hcnt), .o_last(hlast));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [13:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) bad_count++;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [13:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic put_word(input logic [15:0] v);
    @(posedge clk);
    word <= v;
    step(2);
  endtask
  task automatic fire(input logic [15:0] w, input logic [15:0] c);
    @(posedge clk);
    word <= w;
    code <= c;
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    @(posedge clk);
  endtask
  // one state change pulse, then the async pulses
  task automatic state_pulse(input logic [2:0] exp);
    @(posedge clk);
    stc <= 1'b1;
    @(posedge clk);
    stc <= 1'b0;
    @(posedge clk);
    chk({acan, ausb, aser}, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults;
    rchk(`DER_IDX_FACT_MASK, 32'h0000_4024);
    rchk(`DER_IDX_OFF_MASK, 32'h0000_0000);
    rchk(`DER_IDX_QSTOP_MASK, 32'h0000_0000);
    rchk(`DER_IDX_FAULT_MASK, 32'h0000_0000);
    rchk(`DER_IDX_PIN_MASK, 32'h0000_0000);
    rchk(`DER_IDX_PIN_SEL, 32'h0000_0000);
    rchk(`DER_IDX_EMCY_MASK, 32'h0000_FFFF);
    wb(1'b1, `DER_IDX_FACT_MASK, 32'h0000_0000);
    rchk(`DER_IDX_FACT_MASK, 32'h0000_4024);
    rchk(14'h0800, 32'h0000_0000);
    wb(1'b1, `DER_IDX_ROUTING, 32'hFFFF_FFFF);
    rchk(`DER_IDX_ROUTING, 32'h00FF_FFFF);
    chk({icrc, boot}, 2'b10);
    wb(1'b1, `DER_IDX_ROUTING, 32'h0003_0302);
  endtask
  task automatic t_prio;
    wb(1'b1, `DER_IDX_OFF_MASK, 32'h0000_0008);
    wb(1'b1, `DER_IDX_QSTOP_MASK, 32'h0000_0018);
    wb(1'b1, `DER_IDX_FAULT_MASK, 32'h0000_0118);
    wb(1'b1, `DER_IDX_CTRL, 32'h0000_0001);
    wb(1'b1, `DER_IDX_PIN_MASK, 32'h0000_0100);
    wb(1'b1, `DER_IDX_PIN_SEL, 32'h0000_0003);
    en <= 1'b1;
    put_word(16'h0008);
    chk({off, brk, qs, fr, eok, dout}, {5'b11000, 8'h00});
    put_word(16'h0010);
    chk({off, brk, qs, fr, eok, dout}, {5'b00101, 8'h00});
    put_word(16'h0100);
    chk({off, brk, qs, fr, eok, dout}, {5'b00011, 8'h04});
    put_word(16'h0000);
    chk({off, qs, fr, eok}, 4'b0001);
    @(posedge clk);
    tmp <= 1'b1;
    step(2);
    chk({off, eok}, 2'b10);
    tmp <= 1'b0;
    safe_torque_off <= 1'b1;
    step(2);
    chk({off, eok}, 2'b10);
    safe_torque_off <= 1'b0;
    wb(1'b1, `DER_IDX_ROUTING, 32'h0003_0303);
    step(1);
    chk(eok, 1'b0);
    nmt <= 1'b1;
    step(2);
    chk(eok, 1'b1);
  endtask
  task automatic t_supply;
    wb(1'b1, `DER_IDX_TOL_US, 32'h0000_0002);
    sa <= 1'b1;
    step(400);
    chk(off, 1'b0);
    step(700);
    chk(off, 1'b1);
    sa <= 1'b0;
    eb <= 1'b1;
    step(400);
    chk(off, 1'b0);
    step(700);
    chk(off, 1'b1);
    eb <= 1'b0;
    wb(1'b1, `DER_IDX_SUPPLY_MAX, 32'h0000_0064);
    lvl <= 16'h0082;
    step(2);
    chk(off, 1'b0);
    lvl <= 16'h0083;
    step(2);
    chk(off, 1'b1);
    lvl <= 16'h0000;
  endtask
  task automatic t_emcy;
    fire(16'h0024, 16'h1234);
    chk({ecan, eusb, eser, edat}, {3'b111, 64'h0000_0000_240D_1234});
    step(1);
    chk({hcnt, hlast}, {8'h01, 64'h0000_0000_240D_1234});
    rchk(`DER_IDX_ERR_CLASS, 32'h0000_000D);
    state_pulse(3'b111);
    net <= 1'b1;
    fire(16'h2000, 16'h5678);
    chk({ecan, eusb, eser, edat}, {3'b110, 64'h0000_0020_0081_5678});
    state_pulse(3'b110);
    rchk(`DER_IDX_LOG_COUNT, 32'h0000_0002);
    rchk(`DER_IDX_LOG_BASE + 14'h0002, 32'h240D_1234);
    wb(1'b1, `DER_IDX_EMCY_MASK, 32'h0000_0000);
    fire(16'h0024, 16'h1111);
    chk({ecan, eusb, eser, hcnt}, {3'b000, 8'h02});
  endtask
  task automatic t_led;
    logic r;
    led <= 4'b0001;
    step(3);
    chk({grn, red}, 2'b01);
    step(1100);
    chk({grn, red}, 2'b01);
    led <= 4'b1000;
    step(3);
    chk({grn, red}, 2'b10);
    led <= 4'b0100;
    step(3);
    r = red;
    step(1000);
    chk({grn, red ^ r}, 2'b01);
    led <= 4'b0000;
    step(3);
    r = grn;
    step(1000);
    chk({red, grn ^ r}, 2'b01);
  endtask
  task automatic report_and_stop;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_defaults;
    t_prio;
    t_supply;
    t_emcy;
    t_led;
    report_and_stop;
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
endmodule
bind der_dispatch der_dispatch_monitor u_mon (.I_SYS_CLK, .I_RST_B, .I_ERR_WORD, .I_ERR_EVENT, .I_TEMP_OVER,
  .I_SAFE_TORQUE_OFF, .I_NET_MODE, .O_DRIVE_OFF, .O_BRAKE, .O_QUICK_STOP, .O_FAULT_REQ, .O_ENABLE_OK,
  .O_EMCY_DATA, .O_EMCY_CAN, .O_EMCY_SER);
